// ---- common/brt_pkg.sv ----
// Opcodes, lengths, clock counts and carriers for the branch timing block
package brt_pkg;

  // Opcode values and match masks
  localparam logic [7:0] OP_SUB_RETURN = 8'h22;
  localparam logic [7:0] OP_INT_RETURN = 8'h32;
  localparam logic [7:0] OP_ABS_JUMP = 8'h01;
  localparam logic [7:0] OP_ABS_JUMP_MASK = 8'h1f;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_INDIRECT_JUMP = 8'h73;
  localparam logic [7:0] OP_JUMP_ACC_ZERO = 8'h60;
  localparam logic [7:0] OP_JUMP_ACC_NONZERO = 8'h70;
  localparam logic [7:0] OP_CMP_ACC_DIRECT = 8'hb5;
  localparam logic [7:0] OP_CMP_ACC_IMM = 8'hb4;
  localparam logic [7:0] OP_CMP_IND_IMM = 8'hb6;
  localparam logic [7:0] OP_CMP_IND_IMM_MASK = 8'hfe;
  localparam logic [7:0] OP_CMP_REG_IMM = 8'hb8;
  localparam logic [7:0] OP_DEC_REG = 8'hd8;
  localparam logic [7:0] OP_REG_MASK = 8'hf8;
  localparam logic [7:0] OP_DEC_DIRECT = 8'hd5;

  // Encoded lengths in bytes
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // Clock counts in system clocks
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  localparam logic [2:0] CYC_FIVE = 3'h5;
  localparam logic [2:0] CYC_LAST = 3'h1;
  localparam logic [2:0] CYC_NEXT_TO_LAST = 3'h2;

  // Reset values
  localparam logic [15:0] RST_TARGET = 16'h0000;
  localparam logic [2:0] RST_COUNT = 3'h0;

  // Instruction as handed over by fetch
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [15:0] pc;
  } brt_insn_t;

  // Core state the branch decision depends on
  typedef struct packed {
    logic [7:0] acc;
    logic [15:0] data_pointer;
    logic [7:0] operand;
    logic [15:0] stack_pc;
  } brt_ctx_t;

  // Decoded outcome of one branch instruction
  typedef struct packed {
    logic [1:0] len;
    logic [2:0] cycles;
    logic taken;
    logic irq_resume;
    logic [15:0] target;
  } brt_result_t;

endpackage

// ---- logic/brt_cycle_timer.sv ----
// Down counter that paces one instruction's execution clocks
`timescale 1ns/1ps
module brt_cycle_timer
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic load,
  input wire logic [2:0] count,
  output logic [2:0] remain_q
);

  logic [2:0] remain_d;

  always_comb
  begin
    remain_d = remain_q;
    if (load)
    begin
      remain_d = count;
    end
    else if (remain_q != brt_pkg::RST_COUNT)
    begin
      remain_d = remain_q - 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      remain_q <= brt_pkg::RST_COUNT;
    end
    else
    begin
      remain_q <= remain_d;
    end
  end

endmodule

// ---- logic/brt_branch_timing.sv ----
// Branch instruction decoder with length, clock count and target
//
// Overview of operation
// - subroutine_return: one byte, five clocks, pc from stack
// - interrupt_return: one byte, five clocks, resumes flow
// - absolute_jump: two bytes, three clocks
// - long_jump: three bytes, four clocks
// - short_relative_jump: two bytes, three clocks
// - indirect_jump: acc plus data_pointer, one byte, three
// - jump_if_acc_zero: two bytes, two or three clocks
// - jump_if_acc_nonzero: two bytes, two or three clocks
// - compare direct with acc: three bytes, four/five
// - compare immediate with acc: three bytes, three/four
// - compare immediate with register: three bytes, three/four
// - compare immediate with indirect byte: three bytes, three/four
// - decrement register branch: two bytes, two/three
// - decrement direct branch: three bytes, three/four
`timescale 1ns/1ps
module brt_branch_timing
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic insn_valid,
  input wire brt_pkg::brt_insn_t insn,
  input wire brt_pkg::brt_ctx_t ctx,
  output logic insn_ready_q,
  output logic busy_q,
  output logic done_q,
  output logic pc_load_q,
  output logic int_return_q,
  output logic unsupported_q,
  output brt_pkg::brt_result_t result_q
);

  typedef enum logic [1:0] {
    BRT_IDLE = 2'h1,
    BRT_EXEC = 2'h2
  } brt_state_t;

  brt_state_t state_q;
  brt_state_t state_d;
  brt_pkg::brt_result_t dec;
  brt_pkg::brt_result_t result_d;
  logic known;
  logic accept;
  logic busy_d;
  logic done_d;
  logic pc_load_d;
  logic int_return_d;
  logic unsupported_d;
  logic [2:0] remain;
  logic [15:0] next_pc;
  logic [15:0] rel_target;
  logic [7:0] rel;
  logic [7:0] dec_val;

  // Combinational decode of the presented instruction
  always_comb
  begin
    dec = '0;
    known = 1'h1;
    rel = insn.byte1;
    dec_val = ctx.operand - 8'h01;
    next_pc = 16'h0000;
    rel_target = 16'h0000;
    if (insn.opcode == brt_pkg::OP_SUB_RETURN)
    begin
      dec.len = brt_pkg::LEN_ONE;
      dec.cycles = brt_pkg::CYC_FIVE;
      dec.taken = 1'h1;
      dec.target = ctx.stack_pc;
    end
    else if (insn.opcode == brt_pkg::OP_INT_RETURN)
    begin
      dec.len = brt_pkg::LEN_ONE;
      dec.cycles = brt_pkg::CYC_FIVE;
      dec.taken = 1'h1;
      dec.irq_resume = 1'h1;
      dec.target = ctx.stack_pc;
    end
    else if ((insn.opcode & brt_pkg::OP_ABS_JUMP_MASK) == brt_pkg::OP_ABS_JUMP)
    begin
      dec.len = brt_pkg::LEN_TWO;
      dec.cycles = brt_pkg::CYC_THREE;
      dec.taken = 1'h1;
    end
    else if (insn.opcode == brt_pkg::OP_LONG_JUMP)
    begin
      dec.len = brt_pkg::LEN_THREE;
      dec.cycles = brt_pkg::CYC_FOUR;
      dec.taken = 1'h1;
      dec.target = {insn.byte1, insn.byte2};
    end
    else if (insn.opcode == brt_pkg::OP_SHORT_JUMP)
    begin
      dec.len = brt_pkg::LEN_TWO;
      dec.cycles = brt_pkg::CYC_THREE;
      dec.taken = 1'h1;
    end
    else if (insn.opcode == brt_pkg::OP_INDIRECT_JUMP)
    begin
      dec.len = brt_pkg::LEN_ONE;
      dec.cycles = brt_pkg::CYC_THREE;
      dec.taken = 1'h1;
      dec.target = ctx.data_pointer + {8'h00, ctx.acc};
    end
    else if (insn.opcode == brt_pkg::OP_JUMP_ACC_ZERO)
    begin
      dec.len = brt_pkg::LEN_TWO;
      dec.taken = (ctx.acc == 8'h00);
      dec.cycles = dec.taken ? brt_pkg::CYC_THREE : brt_pkg::CYC_TWO;
    end
    else if (insn.opcode == brt_pkg::OP_JUMP_ACC_NONZERO)
    begin
      dec.len = brt_pkg::LEN_TWO;
      dec.taken = (ctx.acc != 8'h00);
      dec.cycles = dec.taken ? brt_pkg::CYC_THREE : brt_pkg::CYC_TWO;
    end
    else if (insn.opcode == brt_pkg::OP_CMP_ACC_DIRECT)
    begin
      dec.len = brt_pkg::LEN_THREE;
      dec.taken = (ctx.acc != ctx.operand);
      dec.cycles = dec.taken ? brt_pkg::CYC_FIVE : brt_pkg::CYC_FOUR;
      rel = insn.byte2;
    end
    else if (insn.opcode == brt_pkg::OP_CMP_ACC_IMM)
    begin
      dec.len = brt_pkg::LEN_THREE;
      dec.taken = (ctx.acc != insn.byte1);
      dec.cycles = dec.taken ? brt_pkg::CYC_FOUR : brt_pkg::CYC_THREE;
      rel = insn.byte2;
    end
    else if ((insn.opcode & brt_pkg::OP_REG_MASK) == brt_pkg::OP_CMP_REG_IMM)
    begin
      dec.len = brt_pkg::LEN_THREE;
      dec.taken = (ctx.operand != insn.byte1);
      dec.cycles = dec.taken ? brt_pkg::CYC_FOUR : brt_pkg::CYC_THREE;
      rel = insn.byte2;
    end
    else if ((insn.opcode & brt_pkg::OP_CMP_IND_IMM_MASK) == brt_pkg::OP_CMP_IND_IMM)
    begin
      dec.len = brt_pkg::LEN_THREE;
      dec.taken = (ctx.operand != insn.byte1);
      dec.cycles = dec.taken ? brt_pkg::CYC_FOUR : brt_pkg::CYC_THREE;
      rel = insn.byte2;
    end
    else if ((insn.opcode & brt_pkg::OP_REG_MASK) == brt_pkg::OP_DEC_REG)
    begin
      dec.len = brt_pkg::LEN_TWO;
      dec.taken = (dec_val != 8'h00);
      dec.cycles = dec.taken ? brt_pkg::CYC_THREE : brt_pkg::CYC_TWO;
    end
    else if (insn.opcode == brt_pkg::OP_DEC_DIRECT)
    begin
      dec.len = brt_pkg::LEN_THREE;
      dec.taken = (dec_val != 8'h00);
      dec.cycles = dec.taken ? brt_pkg::CYC_FOUR : brt_pkg::CYC_THREE;
      rel = insn.byte2;
    end
    else
    begin
      known = 1'h0;
    end
    next_pc = insn.pc + {14'h0000, dec.len};
    rel_target = next_pc + {{8{rel[7]}}, rel};
    if ((insn.opcode & brt_pkg::OP_ABS_JUMP_MASK) == brt_pkg::OP_ABS_JUMP)
    begin
      dec.target = {next_pc[15:11], insn.opcode[7:5], insn.byte1};
    end
    else if (known && (dec.target == brt_pkg::RST_TARGET) && !dec.irq_resume
             && insn.opcode != brt_pkg::OP_SUB_RETURN
             && insn.opcode != brt_pkg::OP_LONG_JUMP
             && insn.opcode != brt_pkg::OP_INDIRECT_JUMP)
    begin
      // Untaken conditionals fall through to the next instruction
      dec.target = dec.taken ? rel_target : next_pc;
    end
  end

  assign accept = insn_valid && insn_ready_q;

  brt_cycle_timer brt_cycle_timer_inst
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(accept && known),
    .count(dec.cycles),
    .remain_q(remain)
  );

  // Sequencing: busy for exactly the decoded number of clocks
  always_comb
  begin
    state_d = state_q;
    busy_d = busy_q;
    done_d = 1'h0;
    pc_load_d = 1'h0;
    int_return_d = 1'h0;
    unsupported_d = 1'h0;
    result_d = result_q;
    unique case (state_q)
      BRT_IDLE:
      begin
        if (accept && known)
        begin
          state_d = BRT_EXEC;
          busy_d = 1'h1;
          result_d = dec;
        end
        else if (accept)
        begin
          unsupported_d = 1'h1;
        end
      end
      BRT_EXEC:
      begin
        if (remain == brt_pkg::CYC_NEXT_TO_LAST)
        begin
          done_d = 1'h1;
          pc_load_d = result_q.taken;
          int_return_d = result_q.irq_resume;
        end
        if (remain == brt_pkg::CYC_LAST)
        begin
          state_d = BRT_IDLE;
          busy_d = 1'h0;
        end
      end
      default:
      begin
        state_d = BRT_IDLE;
        busy_d = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= BRT_IDLE;
      busy_q <= 1'h0;
      insn_ready_q <= 1'h1;
      done_q <= 1'h0;
      pc_load_q <= 1'h0;
      int_return_q <= 1'h0;
      unsupported_q <= 1'h0;
      result_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      busy_q <= busy_d;
      insn_ready_q <= !busy_d;
      done_q <= done_d;
      pc_load_q <= pc_load_d;
      int_return_q <= int_return_d;
      unsupported_q <= unsupported_d;
      result_q <= result_d;
    end
  end

endmodule

// ---- testbench/brt_branch_timing_chk.sv ----
// Timing checker for the branch timing block
`timescale 1ns/1ps
module brt_branch_timing_chk
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic insn_valid,
  input wire brt_pkg::brt_insn_t insn,
  input wire brt_pkg::brt_ctx_t ctx,
  input wire logic insn_ready_q,
  input wire logic busy_q,
  input wire logic done_q,
  input wire logic pc_load_q,
  input wire logic int_return_q,
  input wire logic unsupported_q,
  input wire brt_pkg::brt_result_t result_q
);
  logic [2:0] run_q;
  logic [2:0] run_d;
  logic take;
  assign take = insn_valid && insn_ready_q;
  // Busy cycles seen before the current one
  always_comb
  begin
    run_d = busy_q ? run_q + 3'h1 : 3'h0;
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      run_q <= 3'h0;
    else
      run_q <= run_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  busy_start_a: assert property ($rose(busy_q) |-> $past(take))
    else $error("busy without accept");
  run_len_a: assert property (done_q |-> run_q == result_q.cycles - 3'h1)
    else $error("busy length differs from clock count");
  busy_ready_a: assert property (busy_q |-> !insn_ready_q)
    else $error("ready while busy");
  done_end_a: assert property (done_q |=> !busy_q && insn_ready_q)
    else $error("busy past done");
  load_taken_a: assert property (done_q |-> pc_load_q == result_q.taken)
    else $error("pc load differs from taken");
  load_done_a: assert property (pc_load_q |-> done_q)
    else $error("pc load outside done");
  irq_pulse_a: assert property (int_return_q |-> done_q && result_q.irq_resume)
    else $error("interrupt return pulse misplaced");
  irq_done_a: assert property (done_q && result_q.irq_resume |-> int_return_q)
    else $error("interrupt return pulse missing");
  result_hold_a: assert property (busy_q && $past(busy_q) |-> $stable(result_q))
    else $error("result changed while busy");
  unsup_once_a: assert property (unsupported_q |-> $past(take) && !busy_q)
    else $error("unsupported pulse misplaced");
  cover property (done_q && pc_load_q);
  cover property (done_q && !result_q.taken);
  cover property (int_return_q);
  cover property (unsupported_q);
endmodule
bind brt_branch_timing brt_branch_timing_chk brt_branch_timing_chk_inst (.clk_sys(clk_sys),
  .nrst(nrst), .insn_valid(insn_valid), .insn(insn), .ctx(ctx), .insn_ready_q(insn_ready_q),
  .busy_q(busy_q), .done_q(done_q), .pc_load_q(pc_load_q), .int_return_q(int_return_q),
  .unsupported_q(unsupported_q), .result_q(result_q));

// ---- testbench/brt_branch_timing_test.sv ----
// Self-checking bench for the branch timing block
`timescale 1ns/1ps
module brt_branch_timing_test;
  logic clk_sys;
  logic nrst;
  logic insn_valid;
  brt_pkg::brt_insn_t insn;
  brt_pkg::brt_ctx_t ctx;
  logic insn_ready_q;
  logic busy_q;
  logic done_q;
  logic pc_load_q;
  logic int_return_q;
  logic unsupported_q;
  brt_pkg::brt_result_t result_q;
  brt_pkg::brt_result_t last;
  logic [15:0] pc_v;
  int n_fail;
  int cmp_count;
  int cyc_count;
  brt_branch_timing brt_branch_timing_inst (.clk_sys(clk_sys), .nrst(nrst),
    .insn_valid(insn_valid), .insn(insn), .ctx(ctx), .insn_ready_q(insn_ready_q),
    .busy_q(busy_q), .done_q(done_q), .pc_load_q(pc_load_q), .int_return_q(int_return_q),
    .unsupported_q(unsupported_q), .result_q(result_q));
  initial
  begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_res(input brt_pkg::brt_result_t exp);
    cmp_count++;
    if (result_q !== exp)
    begin
      n_fail++;
      $display("wrong value result expected %h seen %h", exp, result_q);
    end
  endtask
  // One branch; a stray request is held up while busy and must be ignored
  task automatic exec(input logic [7:0] op, input logic [15:0] b, input logic [7:0] acc,
    input logic [7:0] opnd, input logic [2:0] cyc, input logic [1:0] len, input logic tk,
    input logic [15:0] tgt);
    last = '{len, cyc, tk, op == brt_pkg::OP_INT_RETURN, tgt};
    @(posedge clk_sys);
    insn_valid <= 1'h1;
    insn <= '{op, b[15:8], b[7:0], pc_v};
    ctx <= '{acc, 16'hfff0, opnd, 16'h2345};
    @(posedge clk_sys);
    insn <= '{8'h00, 8'h00, 8'h00, pc_v};
    #1;
    chk_res(last);
    chk_bit("busy", 1'h1, busy_q);
    chk_bit("done", cyc == 3'h1, done_q);
    repeat (cyc - 3'h1) @(posedge clk_sys);
    #1;
    chk_bit("done", 1'h1, done_q);
    chk_bit("busy", 1'h1, busy_q);
    chk_bit("ready", 1'h0, insn_ready_q);
    chk_bit("pc_load", tk, pc_load_q);
    chk_bit("int_return", last.irq_resume, int_return_q);
    @(posedge clk_sys);
    insn_valid <= 1'h0;
    #1;
    chk_bit("ready", 1'h1, insn_ready_q);
    chk_bit("busy", 1'h0, busy_q);
    chk_bit("unsupported", 1'h0, unsupported_q);
    chk_res(last);
  endtask
  task automatic t_returns;
    exec(8'h22, 16'h0000, 8'h00, 8'h00, 3'h5, 2'h1, 1'h1, 16'h2345);
    exec(8'h32, 16'h0000, 8'h00, 8'h00, 3'h5, 2'h1, 1'h1, 16'h2345);
  endtask
  task automatic t_jumps;
    pc_v = 16'h17fe;
    exec(8'he1, 16'h3400, 8'h00, 8'h00, 3'h3, 2'h2, 1'h1, 16'h1f34);
    pc_v = 16'h1000;
    exec(8'h02, 16'h1234, 8'h00, 8'h00, 3'h4, 2'h3, 1'h1, 16'h1234);
    exec(8'h80, 16'hfe00, 8'h00, 8'h00, 3'h3, 2'h2, 1'h1, 16'h1000);
    exec(8'h73, 16'h0000, 8'hff, 8'h00, 3'h3, 2'h1, 1'h1, 16'h00ef);
  endtask
  task automatic t_acc;
    exec(8'h60, 16'h1000, 8'h00, 8'h00, 3'h3, 2'h2, 1'h1, 16'h1012);
    exec(8'h60, 16'h1000, 8'h01, 8'h00, 3'h2, 2'h2, 1'h0, 16'h1002);
    exec(8'h70, 16'h8000, 8'h01, 8'h00, 3'h3, 2'h2, 1'h1, 16'h0f82);
    exec(8'h70, 16'h8000, 8'h00, 8'h00, 3'h2, 2'h2, 1'h0, 16'h1002);
  endtask
  task automatic t_cmp;
    exec(8'hb5, 16'h4005, 8'h05, 8'h06, 3'h5, 2'h3, 1'h1, 16'h1008);
    exec(8'hb5, 16'h4005, 8'h05, 8'h05, 3'h4, 2'h3, 1'h0, 16'h1003);
    exec(8'hb4, 16'h08fd, 8'h07, 8'h00, 3'h4, 2'h3, 1'h1, 16'h1000);
    exec(8'hb4, 16'h07fd, 8'h07, 8'h00, 3'h3, 2'h3, 1'h0, 16'h1003);
    exec(8'hb8, 16'h0102, 8'h00, 8'h00, 3'h4, 2'h3, 1'h1, 16'h1005);
    exec(8'hbf, 16'h0102, 8'h00, 8'h01, 3'h3, 2'h3, 1'h0, 16'h1003);
    exec(8'hb6, 16'h097f, 8'h00, 8'h08, 3'h4, 2'h3, 1'h1, 16'h1082);
    exec(8'hb7, 16'h097f, 8'h00, 8'h09, 3'h3, 2'h3, 1'h0, 16'h1003);
  endtask
  task automatic t_dec;
    exec(8'hd8, 16'h0400, 8'h00, 8'h00, 3'h3, 2'h2, 1'h1, 16'h1006);
    exec(8'hdf, 16'h0400, 8'h00, 8'h01, 3'h2, 2'h2, 1'h0, 16'h1002);
    exec(8'hd5, 16'h30f0, 8'h00, 8'h02, 3'h4, 2'h3, 1'h1, 16'h0ff3);
    exec(8'hd5, 16'h30f0, 8'h00, 8'h01, 3'h3, 2'h3, 1'h0, 16'h1003);
  endtask
  // Non-branch opcodes back to back leave the result alone
  task automatic t_unsup;
    @(posedge clk_sys);
    insn_valid <= 1'h1;
    @(posedge clk_sys);
    insn <= '{8'ha5, 8'h00, 8'h00, pc_v};
    #1;
    chk_bit("unsupported", 1'h1, unsupported_q);
    @(posedge clk_sys);
    insn_valid <= 1'h0;
    #1;
    chk_bit("unsupported", 1'h1, unsupported_q);
    chk_bit("busy", 1'h0, busy_q);
    chk_res(last);
  endtask
  task automatic finish_test;
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc_count++;
    if (cyc_count == 2000)
    begin
      n_fail++;
      finish_test;
    end
  end
  initial
  begin
    nrst = 1'h0;
    insn_valid = 1'h0;
    insn = '0;
    ctx = '0;
    pc_v = 16'h1000;
    repeat (10) @(posedge clk_sys);
    chk_bit("ready", 1'h1, insn_ready_q);
    nrst <= 1'h1;
    t_returns;
    t_jumps;
    t_acc;
    t_cmp;
    t_dec;
    t_unsup;
    finish_test;
  end
endmodule
